// ---- bench/decode_monitor.sv ----
// Checker for the move and return decoder
`timescale 1ns/1ps
module decode_monitor #(parameter PC_WIDTH = 13) (
	// Clock, reset and fetch
	input wire                ref_clk, reset_n, insn_valid, busy,
	input wire [13:0]         insn,
	input wire [PC_WIDTH-1:0] stack_top, pc,
	// Results
	input wire                stack_pop, file_we, global_irq_enable, flags_we,
	input wire [6:0]          file_addr,
	input wire [7:0]          file_wdata, acc, option_reg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire take = insn_valid && !busy;
	sequence pop_step;
		stack_pop && busy && global_irq_enable && pc == $past(stack_top);
	endsequence
	lit_load_a: assert property (take && insn[13:10] == 4'hc |=> acc == $past(insn[7:0]))
		else $error("literal load wrong");
	acc_store_a: assert property (take && insn[13:7] == 7'h01 |=> file_we
		&& file_addr == $past(insn[6:0]) && file_wdata == $past(acc)) else $error("store wrong");
	irq_return_a: assert property (take && insn == 14'h0009 |=> pop_step ##1 !busy)
		else $error("interrupt return wrong");
	option_load_a: assert property (take && insn == 14'h0062 |=> option_reg == $past(acc))
		else $error("option load wrong");
	nop_quiet_a: assert property (take && (insn & 14'h3f9f) == 14'h0 |=>
		pc == $past(pc) + 1'b1 && $stable(acc) && !file_we) else $error("no-op changed state");
	flags_quiet_a: assert property (!flags_we) else $error("flags written");
endmodule
bind core_move_return_decode decode_monitor #(.PC_WIDTH(PC_WIDTH)) mon (.ref_clk, .reset_n,
	.insn_valid, .busy, .insn, .stack_top, .pc, .stack_pop, .file_we, .global_irq_enable,
	.flags_we, .file_addr, .file_wdata, .acc, .option_reg);

// ---- bench/prog_mem_model.sv ----
// Program memory model holding a fixed test program
`timescale 1ns/1ps
module prog_mem_model (
	// Fetch port
	input  wire [12:0] addr,
	output reg  [13:0] word
);
	always @* begin
		case (addr)
		13'h0000: word = 14'h30a5;
		13'h0001: word = 14'h00c5;
		13'h0002: word = 14'h0062;
		13'h0003: word = 14'h0060;
		13'h0004: word = 14'h0009;
		13'h0014: word = 14'h0062;
		13'h0018: word = 14'h0009;
		default:  word = 14'h0000;
		endcase
	end
endmodule

// ---- bench/tb_core_move_return_decode.sv ----
// Testbench for the move and return decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_core_move_return_decode;
	reg         ref_clk = 0, reset_n = 0, insn_valid = 0;
	reg         file_ext_we = 0, file_ext_is_option = 0, file_ext_is_irqctl = 0;
	reg  [7:0]  file_ext_wdata = 8'h00;
	wire [13:0] insn;
	wire [12:0] pc, stack_top = 13'h0010;
	wire [7:0]  acc, option_reg, file_wdata, irq_control_reg;
	wire [6:0]  file_addr;
	wire        stack_pop, file_we, global_irq_enable, busy, flags_we;
	integer     error_cnt = 0, n_tests = 0;
	always #4 ref_clk = ~ref_clk;
	prog_mem_model mem (.addr(pc), .word(insn));
	core_move_return_decode dut (.ref_clk, .reset_n, .insn, .insn_valid, .stack_top, .stack_pop,
		.file_we, .file_addr, .file_wdata, .file_ext_we, .file_ext_is_option,
		.file_ext_is_irqctl, .file_ext_wdata, .acc, .option_reg,
		.irq_control_reg, .global_irq_enable, .pc, .busy, .flags_we);
	task step; begin @(posedge ref_clk); #1; end endtask
	task summarize; begin
		$display("tests %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end endtask
	task t_lit; begin
		step;
		`CHK("acc", 8'ha5, acc)
		`CHK("pc", 13'h0001, pc)
		$display("literal load done");
	end endtask
	task t_store; begin
		step;
		`CHK("file_we", 1'b1, file_we)
		`CHK("file_addr", 7'h45, file_addr)
		`CHK("file_wdata", 8'ha5, file_wdata)
		$display("store done");
	end endtask
	task t_opt; begin
		`CHK("option reset", 8'hff, option_reg)
		step;
		`CHK("option_reg", 8'ha5, option_reg)
		$display("option load done");
	end endtask
	task t_nop; begin
		step;
		`CHK("nop pc", 13'h0004, pc)
		`CHK("nop we", 1'b0, file_we)
		`CHK("gie before", 1'b0, global_irq_enable)
		$display("no-op done");
	end endtask
	task t_iret; begin
		step;
		`CHK("ret pc", 13'h0010, pc)
		`CHK("pop", 1'b1, stack_pop)
		`CHK("gie", 1'b1, global_irq_enable)
		`CHK("irq ctl", 8'h80, irq_control_reg)
		`CHK("busy", 1'b1, busy)
		step;
		`CHK("dead pc", 13'h0010, pc)
		`CHK("busy end", 1'b0, busy)
		step;
		`CHK("next pc", 13'h0011, pc)
		$display("interrupt return done");
	end endtask
	task ext_cycle(input opt, input ctl, input [7:0] data); begin
		@(posedge ref_clk);
		file_ext_we        <= 1'b1;
		file_ext_is_option <= opt;
		file_ext_is_irqctl <= ctl;
		file_ext_wdata     <= data;
		@(posedge ref_clk);
		file_ext_we        <= 1'b0;
		#1;
	end endtask
	task t_ext_opt; begin
		ext_cycle(1'b1, 1'b0, 8'h3c);
		`CHK("ext option", 8'h3c, option_reg)
		ext_cycle(1'b1, 1'b0, 8'h5a);
		`CHK("exec over ext", 8'ha5, option_reg)
		$display("option file write done");
	end endtask
	task t_ext_ctl; begin
		ext_cycle(1'b0, 1'b1, 8'h00);
		`CHK("ext gie clear", 1'b0, global_irq_enable)
		`CHK("ext ctl clear", 8'h00, irq_control_reg)
		ext_cycle(1'b0, 1'b1, 8'h00);
		`CHK("set over clear", 8'h80, irq_control_reg)
		`CHK("ret pc again", 13'h0010, pc)
		`CHK("busy again", 1'b1, busy)
		$display("control file write done");
	end endtask
	initial begin
		#100000;
		error_cnt++;
		summarize;
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		insn_valid <= 1'b1;
		t_lit;
		t_store;
		t_opt;
		t_nop;
		t_iret;
		t_ext_opt;
		t_ext_ctl;
		summarize;
	end
endmodule

// ---- hdl/core_move_return_decode.v ----
// Decode and execute for literal load, store, no-op, interrupt return, option load
//
// How it works
// RL1: 11_00xx opcode loads literal into accumulator
// RL2: 00_0000_1fff_ffff stores accumulator to file register
// RL3: Interrupt return pops stack, sets enable, two cycles
// RL4: Legacy opcode copies accumulator into option register
// RL5: No-op only advances the program counter
`timescale 1ns/1ps
`include "core_decode_consts.vh"

module core_move_return_decode #(
	parameter PC_WIDTH = 13
) (
	// Clock and reset
	input  wire                ref_clk,
	input  wire                reset_n,
	// Program memory
	input  wire [13:0]         insn,
	input  wire                insn_valid,
	// Stack
	input  wire [PC_WIDTH-1:0] stack_top,
	output reg                 stack_pop,
	// File register bus
	output reg                 file_we,
	output reg  [6:0]          file_addr,
	output reg  [7:0]          file_wdata,
	input  wire                file_ext_we,
	input  wire                file_ext_is_option,
	input  wire                file_ext_is_irqctl,
	input  wire [7:0]          file_ext_wdata,
	// Core state
	output wire [7:0]          acc,
	output wire [7:0]          option_reg,
	output wire [7:0]          irq_control_reg,
	output wire                global_irq_enable,
	output wire [PC_WIDTH-1:0] pc,
	output wire                busy,
	output wire                flags_we
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire is_lit;
	wire is_store;
	wire is_iret;
	wire is_optload;
	wire is_nop;

	opcode_classify u_classify (
		.insn       (insn),
		.is_lit     (is_lit),
		.is_store   (is_store),
		.is_iret    (is_iret),
		.is_optload (is_optload),
		.is_nop     (is_nop)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	localparam [1:0] ST_RUN   = 2'b01;
	localparam [1:0] ST_FLUSH = 2'b10;

	reg  [1:0]          state_q;
	reg  [1:0]          state_d;
	reg  [7:0]          acc_q;
	reg  [7:0]          option_q;
	reg  [7:0]          irqctl_q;
	reg  [PC_WIDTH-1:0] pc_q;

	wire run  = (state_q == ST_RUN) && insn_valid;

	always @* begin
		case (state_q)
			ST_RUN:   state_d = (run && is_iret) ? ST_FLUSH : ST_RUN; // [RL3]
			ST_FLUSH: state_d = ST_RUN;
			default:  state_d = ST_RUN;
		endcase
	end

	// ----------------------------------------
	// Instruction class
	// ----------------------------------------
	// Classes never overlap, so one plain case picks the action
	localparam [4:0] CL_LIT     = 5'h01;
	localparam [4:0] CL_STORE   = 5'h02;
	localparam [4:0] CL_IRET    = 5'h04;
	localparam [4:0] CL_OPTLOAD = 5'h08;
	localparam [4:0] CL_NOP     = 5'h10;

	localparam [PC_WIDTH-1:0] PC_ONE = {{(PC_WIDTH-1){1'b0}}, 1'b1};

	wire [4:0] op_class;
	wire       iret_take;
	wire       opt_wr;
	wire       ctl_wr;

	assign op_class  = {is_nop, is_optload, is_iret, is_store, is_lit};
	assign iret_take = run && is_iret;
	// Plain file writes reach both registers; execution overrides them
	assign opt_wr    = file_ext_we && file_ext_is_option;
	assign ctl_wr    = file_ext_we && file_ext_is_irqctl;

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	reg  [7:0]          acc_d;
	reg  [7:0]          option_d;
	reg  [PC_WIDTH-1:0] pc_d;
	reg                 stack_pop_d;
	reg                 file_we_d;
	reg  [6:0]          file_addr_d;
	reg  [7:0]          file_wdata_d;

	always @* begin
		acc_d        = acc_q;
		option_d     = opt_wr ? file_ext_wdata : option_q; // [RL4]
		pc_d         = pc_q;
		stack_pop_d  = 1'b0;
		file_we_d    = 1'b0;
		// Address and data hold after the strobe for a slow file port
		file_addr_d  = file_addr;
		file_wdata_d = file_wdata;
		if (run) begin
			pc_d = pc_q + PC_ONE; // [RL5]
			case (op_class)
				CL_LIT: begin
					acc_d = insn[`LIT_MSB:0]; // [RL1]
				end
				CL_STORE: begin
					file_we_d    = 1'b1; // [RL2]
					file_addr_d  = insn[`FADDR_MSB:0];
					file_wdata_d = acc_q;
				end
				CL_IRET: begin
					pc_d        = stack_top; // [RL3]
					stack_pop_d = 1'b1;
				end
				CL_OPTLOAD: begin
					option_d = acc_q; // [RL4]
				end
				CL_NOP: begin
					// Counter advance above is all it does
				end
				default: begin
					// Opcodes handled elsewhere only move the counter here
				end
			endcase
		end
	end

	// ----------------------------------------
	// Interrupt control register
	// ----------------------------------------
	// Each bit follows the file port or holds; interrupt return also sets the enable bit
	wire [7:0] irqctl_d;
	genvar     b;

	generate
		for (b = 0; b < 8; b = b + 1) begin : g_irqctl
			if (b == `GIE_BIT) begin : g_gie
				// Set wins over a software clear landing on the same edge
				assign irqctl_d[b] = iret_take | (ctl_wr ? file_ext_wdata[b] : irqctl_q[b]); // [RL3]
			end else begin : g_other
				assign irqctl_d[b] = ctl_wr ? file_ext_wdata[b] : irqctl_q[b];
			end
		end
	endgenerate

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d; // [RL3]
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q    <= `ACC_RST;
			option_q <= `OPTION_RST;
			irqctl_q <= `IRQCTL_RST;
		end else begin
			acc_q    <= acc_d;
			option_q <= option_d;
			irqctl_q <= irqctl_d;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_q      <= `PC_RST;
			stack_pop <= 1'b0;
		end else begin
			pc_q      <= pc_d;
			stack_pop <= stack_pop_d;
		end
	end

	// File port: strobe lasts one cycle, address and data hold
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			file_we    <= 1'b0;
			file_addr  <= 7'h00;
			file_wdata <= 8'h00;
		end else begin
			file_we    <= file_we_d;
			file_addr  <= file_addr_d;
			file_wdata <= file_wdata_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// None of these instructions touch the status flags
	assign flags_we          = 1'b0; // [RL1] [RL2] [RL3] [RL4] [RL5]
	assign busy              = (state_q == ST_FLUSH);
	assign acc               = acc_q;
	assign option_reg        = option_q;
	assign irq_control_reg   = irqctl_q;
	assign global_irq_enable = irqctl_q[`GIE_BIT];
	assign pc                = pc_q;

endmodule

// ---- hdl/opcode_classify.v ----
// Combinational opcode classifier for the five handled instructions
`timescale 1ns/1ps
`include "core_decode_consts.vh"

module opcode_classify (
	// Instruction word
	input  wire [13:0] insn,
	// One-hot class outputs
	output wire        is_lit,
	output wire        is_store,
	output wire        is_iret,
	output wire        is_optload,
	output wire        is_nop
);

	assign is_lit     = (insn[13:10] == `LIT_TOP_PAT);
	assign is_store   = (insn[13:8] == 6'h00) && insn[`STORE_BIT];
	assign is_iret    = (insn[13:7] == `CLR_TOP_PAT) && (insn[6:0] == `IRET_LOW);
	assign is_optload = (insn[13:7] == `CLR_TOP_PAT) && (insn[6:0] == `OPTLOAD_LOW);
	// Bits 5 and 6 are don't-care
	assign is_nop     = ((insn & `NOP_MASK) == 14'h0000);

endmodule

// ---- include/core_decode_consts.vh ----
// Constants for the move / return instruction decoder
`ifndef CORE_DECODE_CONSTS_VH
`define CORE_DECODE_CONSTS_VH

// ----------------------------------------
// Instruction word layout
// ----------------------------------------
`define INSN_WIDTH        14
`define LIT_MSB           7
`define FADDR_MSB         6
`define STORE_BIT         7

// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define LIT_TOP_PAT       4'hc
`define CLR_TOP_PAT       7'h00
`define IRET_LOW          7'h09
`define OPTLOAD_LOW       7'h62
`define NOP_MASK          14'h3f9f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACC_RST           8'h00
`define OPTION_RST        8'hff
`define IRQCTL_RST        8'h00
`define PC_RST            13'h0000
`define GIE_BIT           7

// ----------------------------------------
// Timing
// ----------------------------------------
`define IRET_CYCLES       2

`endif
